// ### rtl/eepc_addr_check.v
`timescale 1ns/1ps
`default_nettype none
`include "eepc_defs.vh"

module eepc_addr_check #(
	parameter ARR_BYTES = 512,
	parameter BLK_BYTES = 128
) (
	// target address
	input  wire [15:0] addr,
	// classification
	output wire        in_array,
	output wire        in_secure,
	output wire [1:0]  blk_idx
);
	wire [15:0] off;
	wire [31:0] blk_full;

	assign off       = addr - `EEPC_ARR_BASE;
	assign in_array  = (addr >= `EEPC_ARR_BASE) && (off < ARR_BYTES);
	assign in_secure = (addr >= `EEPC_SEC_BASE) && (addr <= `EEPC_SEC_LAST);
	assign blk_full  = off / BLK_BYTES;
	assign blk_idx   = blk_full[1:0];
endmodule

`default_nettype wire

// ### rtl/eepc_ctrl.v
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "eepc_defs.vh"

module eepc_ctrl #(
	parameter ARR_BYTES = 512,
	parameter BLK_BYTES = 128
) (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// power mode inputs
	input  wire        stop_mode,
	input  wire        wait_mode,
	// nonvolatile configuration cell
	input  wire [7:0]  nv_cfg_in,
	output reg         nv_cfg_write,
	output reg  [7:0]  nv_cfg_wdata,
	// array and charge pump
	output reg         array_enable,
	output reg         pump_on,
	output reg         pump_clk_bus,
	output reg  [1:0]  array_mode,
	output reg  [15:0] array_addr,
	output reg  [7:0]  array_data,
	output reg  [7:0]  cfg_shadow
);
	reg  [7:0]  ctrl_r;
	reg  [7:0]  shadow_r;
	reg  [7:0]  nvcfg_r;
	reg  [15:0] tgt_addr_r;
	reg  [7:0]  tgt_data_r;
	reg         valid_r;
	reg         nonee_r;
	reg         load_r;
	reg         lock_r;
	reg  [7:0]  ctrl_nxt;
	reg  [31:0] rdata_nxt;

	wire        in_array;
	wire        in_secure;
	wire [1:0]  blk_idx;
	wire [15:0] wr_addr;
	wire        wr_en;
	wire        rd_en;
	wire        hv_on;
	wire        hv_set;
	wire        latch_on;
	wire        blocked;
	wire        nv_target;
	wire        wr_valid;
	wire        wr_addr_sec;
	wire        wr_in_arr;
	wire [1:0]  wr_blk;

	assign wr_en    = psel && penable && pwrite;
	assign rd_en    = psel && penable && !pwrite;
	assign wr_addr  = pwdata[15:0];
	assign hv_on    = ctrl_r[`EEPC_CTL_HV];
	assign latch_on = ctrl_r[`EEPC_CTL_LATCH];
	assign nv_target = tgt_addr_r == 16'hFFFF;

	eepc_addr_check #(
		.ARR_BYTES(ARR_BYTES),
		.BLK_BYTES(BLK_BYTES)
	) u_tgt_chk (
		.addr      (tgt_addr_r),
		.in_array  (in_array),
		.in_secure (in_secure),
		.blk_idx   (blk_idx)
	);

	eepc_addr_check #(
		.ARR_BYTES(ARR_BYTES),
		.BLK_BYTES(BLK_BYTES)
	) u_wr_chk (
		.addr      (wr_addr),
		.in_array  (wr_in_arr),
		.in_secure (wr_addr_sec),
		.blk_idx   (wr_blk)
	);

	// secure bytes stop qualifying once locked
	assign wr_valid = (wr_in_arr || wr_addr_sec) && !(lock_r && wr_addr_sec);

	// protection gates the high voltage
	assign blocked = (in_array && shadow_r[`EEPC_CFG_BP_LO + blk_idx]) ||
		(lock_r && in_secure) ||
		(lock_r && nv_target) ||
		(lock_r && ctrl_r[`EEPC_CTL_RAS_HI]) ||
		(ctrl_r[`EEPC_CTL_RAS_HI] && ctrl_r[`EEPC_CTL_RAS_LO] &&
			(shadow_r[3:0] != 4'h0));

	// control register next value
	always @* begin
		ctrl_nxt = ctrl_r;
		if (wr_en && paddr == `EEPC_ADDR_CTRL) begin
			if (!(latch_on && !valid_r)) begin
				ctrl_nxt = pwdata[7:0] & `EEPC_CTL_MASK;
				// mode frozen while hv on
				if (hv_on) begin
					ctrl_nxt[`EEPC_CTL_RAS_HI] = ctrl_r[`EEPC_CTL_RAS_HI];
					ctrl_nxt[`EEPC_CTL_RAS_LO] = ctrl_r[`EEPC_CTL_RAS_LO];
				end
				if (hv_on && !pwdata[`EEPC_CTL_LATCH]) begin
					ctrl_nxt[`EEPC_CTL_LATCH] = 1'b1;
				end
				// refuse hv without latch after non-array write
				if (!hv_on && pwdata[`EEPC_CTL_HV] &&
					(!pwdata[`EEPC_CTL_LATCH] || !latch_on) && nonee_r) begin
					ctrl_nxt[`EEPC_CTL_HV] = 1'b0;
				end
				if (!hv_on && pwdata[`EEPC_CTL_HV] && !latch_on) begin
					ctrl_nxt[`EEPC_CTL_HV] = 1'b0;
				end
				if (!hv_on && pwdata[`EEPC_CTL_HV] && ctrl_r[`EEPC_CTL_PWRDN]) begin
					ctrl_nxt[`EEPC_CTL_HV] = 1'b0;
				end
			end
		end
	end

	assign hv_set = hv_on && latch_on && valid_r && !blocked;

	// registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r     <= 8'h00;
			shadow_r   <= 8'h00;
			nvcfg_r    <= `EEPC_CFG_RESET;
			tgt_addr_r <= 16'h0000;
			tgt_data_r <= 8'h00;
			valid_r    <= 1'b0;
			nonee_r    <= 1'b0;
			load_r     <= 1'b1;
			lock_r     <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			// shadow load after reset release
			load_r <= 1'b0;
			if (load_r) begin
				nvcfg_r  <= nv_cfg_in;
				shadow_r <= nv_cfg_in;
			end else if (rd_en && paddr == `EEPC_ADDR_NVCFG) begin
				shadow_r <= nvcfg_r;
			end
			// lock is sticky and released only by reset
			if (!shadow_r[`EEPC_CFG_SECURE] && !load_r) begin
				lock_r <= 1'b1;
			end
			// target write capture
			if (wr_en && paddr == `EEPC_ADDR_WRITE) begin
				if (latch_on && !hv_on && wr_valid) begin
					tgt_addr_r <= wr_addr;
					tgt_data_r <= pwdata[23:16];
					valid_r    <= 1'b1;
					nonee_r    <= 1'b0;
				end else if (!wr_valid) begin
					nonee_r <= 1'b1;
				end
			end else if (wr_en && paddr == `EEPC_ADDR_NVCFG && latch_on && !hv_on &&
				!lock_r) begin
				tgt_addr_r <= 16'hFFFF;
				tgt_data_r <= pwdata[7:0];
				valid_r    <= 1'b1;
				nonee_r    <= 1'b0;
			end
			if (!ctrl_nxt[`EEPC_CTL_LATCH]) begin
				valid_r <= 1'b0;
			end
			// program of the nonvolatile byte on hv falling
			if (hv_on && !ctrl_nxt[`EEPC_CTL_HV] && nv_target && valid_r &&
				!blocked && !lock_r) begin
				if (ctrl_r[`EEPC_CTL_RAS_LO]) begin
					nvcfg_r <= 8'hFF;
				end else begin
					nvcfg_r <= nvcfg_r & tgt_data_r;
				end
			end else if (load_r) begin
				nvcfg_r <= nv_cfg_in;
			end
		end
	end

	// output and bus registers
	always @* begin
		rdata_nxt = 32'h0000_0000;
		case (paddr)
			`EEPC_ADDR_CTRL:   rdata_nxt = {24'h000000, ctrl_r};
			`EEPC_ADDR_NVCFG:  rdata_nxt = {24'h000000, nvcfg_r};
			`EEPC_ADDR_SHADOW: rdata_nxt = {24'h000000, shadow_r};
			`EEPC_ADDR_STATUS: rdata_nxt = {28'h0000000, lock_r, nonee_r, valid_r, hv_set};
			`EEPC_ADDR_TARGET: rdata_nxt = {8'h00, tgt_data_r, tgt_addr_r};
			default:           rdata_nxt = 32'h0000_0000;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata       <= 32'h0000_0000;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			nv_cfg_write <= 1'b0;
			nv_cfg_wdata <= 8'h00;
			array_enable <= 1'b0;
			pump_on      <= 1'b0;
			pump_clk_bus <= 1'b0;
			array_mode   <= 2'h0;
			array_addr   <= 16'h0000;
			array_data   <= 8'h00;
			cfg_shadow   <= 8'h00;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && (paddr > `EEPC_ADDR_TARGET) &&
				(paddr != `EEPC_ADDR_WRITE);
			prdata  <= (psel && !penable && !pwrite) ? rdata_nxt : 32'h0000_0000;
			nv_cfg_write <= hv_on && !ctrl_nxt[`EEPC_CTL_HV] && nv_target && valid_r &&
				!blocked && !lock_r;
			nv_cfg_wdata <= ctrl_r[`EEPC_CTL_RAS_LO] ? 8'hFF : (nvcfg_r & tgt_data_r);
			array_enable <= !ctrl_nxt[`EEPC_CTL_PWRDN];
			// stop drops the pump, hv bit kept; wait has no effect
			pump_on      <= ctrl_nxt[`EEPC_CTL_HV] && ctrl_nxt[`EEPC_CTL_LATCH] &&
				valid_r && !blocked && !stop_mode && !ctrl_nxt[`EEPC_CTL_PWRDN];
			pump_clk_bus <= ctrl_nxt[`EEPC_CTL_PUMPCLK];
			array_mode   <= {ctrl_nxt[`EEPC_CTL_RAS_HI], ctrl_nxt[`EEPC_CTL_RAS_LO]};
			array_addr   <= tgt_addr_r;
			array_data   <= tgt_data_r;
			cfg_shadow   <= shadow_r;
		end
	end

	wire unused_ok = wait_mode;
endmodule

`default_nettype wire

// ### rtl/eepc_defs.vh
`ifndef EEPC_DEFS_VH
`define EEPC_DEFS_VH

// register byte addresses on the apb bus
`define EEPC_ADDR_CTRL      12'h000
`define EEPC_ADDR_NVCFG     12'h004
`define EEPC_ADDR_SHADOW    12'h008
`define EEPC_ADDR_STATUS    12'h00C
`define EEPC_ADDR_TARGET    12'h010
`define EEPC_ADDR_WRITE     12'h014
`define EEPC_ADDR_POWER     12'h018

// control register fields
`define EEPC_CTL_PUMPCLK    7
`define EEPC_CTL_PWRDN      4
`define EEPC_CTL_RAS_HI     3
`define EEPC_CTL_RAS_LO     2
`define EEPC_CTL_LATCH      1
`define EEPC_CTL_HV         0
`define EEPC_CTL_MASK       8'h9F

// configuration byte fields
`define EEPC_CFG_REDUND     7
`define EEPC_CFG_SECURE     4
`define EEPC_CFG_BP_LO      0
`define EEPC_CFG_RESET      8'h10

// program and erase mode codes
`define EEPC_MODE_PROG      2'h0
`define EEPC_MODE_BYTE_ERA  2'h1
`define EEPC_MODE_BLK_ERA   2'h2
`define EEPC_MODE_BULK_ERA  2'h3

// array address map
`define EEPC_ARR_BASE       16'h0600
`define EEPC_SEC_BASE       16'h08F0
`define EEPC_SEC_LAST       16'h08FF

`endif

// ### tb/eepc_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module eepc_ctrl_sva (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	// power and array
	input wire logic        stop_mode,
	input wire logic [7:0]  nv_cfg_in,
	input wire logic        array_enable,
	input wire logic        pump_on,
	input wire logic        pump_clk_bus,
	input wire logic [1:0]  array_mode,
	input wire logic [15:0] array_addr,
	input wire logic [7:0]  cfg_shadow
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pump_powered: assert property (pump_on |-> array_enable)
		else $error("pump on while powered down");
	a_stop_drop: assert property (stop_mode && $past(stop_mode) |-> !pump_on)
		else $error("pump on in stop");
	a_mode_frozen: assert property (pump_on && $past(pump_on) |-> $stable(array_mode))
		else $error("mode changed under high voltage");
	a_secure_guard: assert property (pump_on && !cfg_shadow[4] |->
		!(array_addr inside {[16'h08F0:16'h08FF]}))
		else $error("secured byte written");
	a_block_guard: assert property (pump_on && array_addr[15:9] == 7'h03 |->
		!cfg_shadow[array_addr[8:7]])
		else $error("protected block written");
	a_bulk_guard: assert property (pump_on && array_mode == 2'h3 |-> cfg_shadow[3:0] == 4'h0)
		else $error("bulk erase with protect set");
	a_reset_load: assert property ($rose(presetn) |=> ##1
		cfg_shadow == $past(nv_cfg_in, 2))
		else $error("shadow not loaded at reset");
	a_reset_vals: assert property ($rose(presetn) |-> !pump_clk_bus && !pump_on && array_mode == 2'h0)
		else $error("control outputs not cleared");
	a_read_reload: assert property (psel && penable && !pwrite && paddr == 12'h004 |->
		##[1:2] cfg_shadow == nv_cfg_in)
		else $error("shadow not reloaded by read");
	cover property (pump_on);
	cover property ($fell(stop_mode) ##[1:3] pump_on);
	cover property (!array_enable);
endmodule
bind eepc_ctrl eepc_ctrl_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .stop_mode(stop_mode),
	.nv_cfg_in(nv_cfg_in), .array_enable(array_enable), .pump_on(pump_on),
	.pump_clk_bus(pump_clk_bus), .array_mode(array_mode), .array_addr(array_addr),
	.cfg_shadow(cfg_shadow));
`default_nettype wire

// ### tb/eepc_nv_cell.sv
`timescale 1ns/1ps
`default_nettype none
module eepc_nv_cell #(
	parameter logic [7:0] INIT = 8'h12
) (
	// clock
	input wire logic       pclk,
	// cell port
	input wire logic       nv_cfg_write,
	input wire logic [7:0] nv_cfg_wdata,
	output var logic [7:0] nv_cfg_in
);
	// unlocked, block one protected, redundant bit zero
	initial nv_cfg_in = INIT;
	// contents survive reset
	always @(posedge pclk) begin
		if (nv_cfg_write) begin
			nv_cfg_in <= nv_cfg_wdata;
		end
	end
endmodule
`default_nettype wire

// ### tb/eeprom_program_erase_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_program_erase_control_test;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        stop_mode = 1'b0, wait_mode = 1'b0, pready, pslverr, e;
	logic        nv_cfg_write, array_enable, pump_on, pump_clk_bus;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [7:0]  nv_cfg_in, nv_cfg_wdata, array_data, cfg_shadow;
	logic [1:0]  array_mode;
	logic [15:0] array_addr;
	int          errors = 0, samples_checked = 0;
	localparam int POWER_ON_RECOVERY_CYCLES = 4;
	localparam int STOP_RECOVERY_CYCLES     = 3;
	always #12.5 pclk = ~pclk;
	eepc_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .stop_mode(stop_mode), .wait_mode(wait_mode),
		.nv_cfg_in(nv_cfg_in), .nv_cfg_write(nv_cfg_write), .nv_cfg_wdata(nv_cfg_wdata),
		.array_enable(array_enable), .pump_on(pump_on), .pump_clk_bus(pump_clk_bus),
		.array_mode(array_mode), .array_addr(array_addr), .array_data(array_data),
		.cfg_shadow(cfg_shadow));
	eepc_nv_cell u_nv (.pclk(pclk), .nv_cfg_write(nv_cfg_write),
		.nv_cfg_wdata(nv_cfg_wdata), .nv_cfg_in(nv_cfg_in));
	task automatic final_report;
		if (errors == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			$display("[ERR] %0t no pready", $time);
			final_report();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	task automatic arm(input logic [31:0] c, input logic [31:0] t);
		wr(12'h000, c);
		wr(12'h014, t);
		wr(12'h000, c | 32'h1);
		repeat (2) @(posedge pclk);
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rd(12'h000, 32'h0);
		chk(array_enable, 32'h1);
		rd(12'h008, 32'h12);
		xfer(1'b0, 12'h004, 32'h0);
		chk(cfg_shadow, 32'h12);
		xfer(1'b0, 12'h01C, 32'h0);
		chk(e, 32'h1);
		wr(12'h014, 32'h0000_0100);
		rd(12'h00C, 32'h4);
		wr(12'h000, 32'h1);
		rd(12'h000, 32'h0);
		for (int m = 0; m < 4; m++) begin
			arm(32'(2 | (m << 2)), 32'h00A50610);
			chk(array_mode, 32'(m));
			chk(pump_on, 32'(m != 3));
			if (m == 0) begin
				rd(12'h010, 32'h00A50610);
				chk(array_addr, 32'h0610);
				chk(array_data, 32'hA5);
				rd(12'h00C, 32'h3);
				stop_mode <= 1'b1;
				repeat (3) @(posedge pclk);
				chk(pump_on, 32'h0);
				rd(12'h000, 32'h3);
				stop_mode <= 1'b0;
				repeat (STOP_RECOVERY_CYCLES) @(posedge pclk);
				chk(pump_on, 32'h1);
				wait_mode <= 1'b1;
				repeat (3) @(posedge pclk);
				chk(pump_on, 32'h1);
				wait_mode <= 1'b0;
			end
			wr(12'h000, 32'(m << 2));
			rd(12'h000, 32'(2 | (m << 2)));
			wr(12'h000, 32'h0);
			rd(12'h000, 32'h0);
		end
		arm(32'h2, 32'h00A50690);
		chk(pump_on, 32'h0);
		wr(12'h000, 32'h0);
		wr(12'h000, 32'h10);
		repeat (2) @(posedge pclk);
		chk(array_enable, 32'h0);
		arm(32'h12, 32'h00A50610);
		chk(pump_on, 32'h0);
		rd(12'h000, 32'h12);
		wr(12'h000, 32'h10);
		wr(12'h000, 32'h80);
		repeat (POWER_ON_RECOVERY_CYCLES) @(posedge pclk);
		chk(pump_clk_bus, 32'h1);
		chk(array_enable, 32'h1);
		// program the config byte: clear block one protect
		wr(12'h000, 32'h2);
		wr(12'h004, 32'h10);
		wr(12'h000, 32'h3);
		wr(12'h000, 32'h0);
		wr(12'h000, 32'h0);
		rd(12'h008, 32'h12);
		rd(12'h004, 32'h10);
		rd(12'h008, 32'h10);
		arm(32'h2, 32'h00A50690);
		chk(pump_on, 32'h1);
		// mid-run reset reloads the new byte
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rd(12'h000, 32'h0);
		rd(12'h008, 32'h10);
		// program the security bit to zero
		wr(12'h000, 32'h2);
		wr(12'h004, 32'h0);
		wr(12'h000, 32'h3);
		wr(12'h000, 32'h0);
		wr(12'h000, 32'h0);
		rd(12'h004, 32'h0);
		rd(12'h00C, 32'h8);
		wr(12'h000, 32'h6);
		wr(12'h004, 32'hFF);
		wr(12'h000, 32'h7);
		rd(12'h000, 32'h6);
		wr(12'h014, 32'h00A508F5);
		rd(12'h00C, 32'hC);
		final_report();
	end
endmodule
`default_nettype wire
